// >>> hw/ppom_port.v
// Port B pin override block with AXI4-Lite register access.
// Assumes peripherals on the same clock drive the override controls and
// the pad wiring resolves pad_out, pad_oe and pullup_en into the pin.
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "ppom_map.vh"
module ppom_port #(
  parameter WIDTH = 8
) (
  input wire clock,
  input wire rst_n,
  input wire [`PPOM_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`PPOM_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  output wire irq,
  input wire sleep_active,
  input wire [`PPOM_SLP_W-1:0] sleep_mode,
  input wire [WIDTH-1:0] toggle_override_en,
  input wire spi_enable,
  input wire spi_master,
  input wire spi_slave_out,
  input wire spi_master_out,
  input wire spi_sck_out,
  input wire timer0_compare_a_en,
  input wire timer0_compare_a_out,
  input wire timer1_compare_c_en,
  input wire timer1_compare_c_out,
  output wire [WIDTH-1:0] pin_change_src,
  output wire timer1_ext_clock_in,
  output wire spi_master_in,
  output wire spi_slave_in,
  output wire spi_sck_in,
  output wire spi_ss_in,
  output wire serial_prog_data_in,
  output wire serial_prog_data_out,
  input wire [WIDTH-1:0] pad_in,
  output wire [WIDTH-1:0] pad_out,
  output wire [WIDTH-1:0] pad_oe,
  output wire [WIDTH-1:0] pullup_en,
  output wire [WIDTH-1:0] analog_pad_path
);
  reg [WIDTH-1:0] dir_q, data_q, data_d, status_q, status_d;
  reg [WIDTH-1:0] mask_q, exten_q, edgeen_q, sample_prev_q;
  reg [WIDTH-1:0] wdata_q, rd_val;
  reg [`PPOM_CTRL_W-1:0] ctrl_q;
  reg [`PPOM_ADDR_W-1:0] awaddr_q;
  reg [31:0] rdata_q;
  reg [1:0] bresp_q, rresp_q;
  reg irq_q, aw_rdy_q, w_rdy_q, aw_have_q, w_have_q, wlane_q;
  reg bvalid_q, ar_rdy_q, rvalid_q, rd_ok;
  wire [WIDTH-1:0] sample, di, events, pu_oe, pu_ov;
  wire [WIDTH-1:0] dd_oe, pv_oe, pv_ov, die_oe;
  wire do_write, port_data_write_strobe, pin_toggle_write_strobe;
  wire pin_read_strobe, global_pullup_disable, pcie, sleep_clamp, spi_m;

  function hit;
    input [`PPOM_ADDR_W-1:0] addr;
    input [`PPOM_ADDR_W-1:0] off;
    begin
      hit = (addr[`PPOM_ADDR_W-1:2] == off[`PPOM_ADDR_W-1:2]);
    end
  endfunction

  function mapped;
    input [`PPOM_ADDR_W-1:0] addr;
    begin
      mapped = hit(addr, `PPOM_OFF_DIR) | hit(addr, `PPOM_OFF_DATA) |
               hit(addr, `PPOM_OFF_PIN) | hit(addr, `PPOM_OFF_CTRL) |
               hit(addr, `PPOM_OFF_STATUS) | hit(addr, `PPOM_OFF_MASK) |
               hit(addr, `PPOM_OFF_EXTEN) | hit(addr, `PPOM_OFF_EDGEEN);
    end
  endfunction

  assign global_pullup_disable = ctrl_q[`PPOM_CTRL_PUD_BIT];
  assign pcie = ctrl_q[`PPOM_CTRL_PCIE_BIT];
  // One clamp and one pull-up disable serve every pin of the port.
  assign sleep_clamp = sleep_active &
                       ((sleep_mode == `PPOM_SLP_PDOWN) |
                        (sleep_mode == `PPOM_SLP_PSAVE) |
                        (sleep_mode == `PPOM_SLP_STANDBY));

  // Alternate function overrides, one set per pin.
  assign spi_m = spi_enable & spi_master;
  assign pu_oe = {{(WIDTH-4){1'b0}}, {4{spi_m}}};
  assign pu_ov = {{(WIDTH-4){1'b0}},
                  data_q[3:0] & {4{global_pullup_disable}}};
  assign dd_oe = {{(WIDTH-4){1'b0}}, {4{spi_m}}};
  assign pv_oe = {timer0_compare_a_en | timer1_compare_c_en,
                  {(WIDTH-5){1'b0}}, {3{spi_m}}, 1'b0};
  // Compare A takes the pin when both timers claim it.
  assign pv_ov = {timer0_compare_a_en ? timer0_compare_a_out
                                      : timer1_compare_c_out,
                  {(WIDTH-5){1'b0}},
                  spi_slave_out, spi_master_out, spi_sck_out,
                  1'b0};
  assign die_oe = edgeen_q & {WIDTH{pcie}};

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_pin
      ppom_pin_cell u_cell (
        .clock(clock),
        .rst_n(rst_n),
        .pad_in(pad_in[gi]),
        .pin_direction_bit(dir_q[gi]),
        .pin_output_data_bit(data_q[gi]),
        .global_pullup_disable(global_pullup_disable),
        .sleep_clamp(sleep_clamp),
        .ext_int_en(exten_q[gi]),
        .pullup_override_en(pu_oe[gi]),
        .pullup_override_val(pu_ov[gi]),
        .dir_override_en(dd_oe[gi]),
        .dir_override_val(1'b0),
        .outval_override_en(pv_oe[gi]),
        .outval_override_val(pv_ov[gi]),
        .inen_override_en(die_oe[gi]),
        .inen_override_val(1'b1),
        .pad_out(pad_out[gi]),
        .pad_oe(pad_oe[gi]),
        .pullup_en(pullup_en[gi]),
        .periph_digital_in(di[gi]),
        .pin_input_sample_bit(sample[gi])
      );
    end
  endgenerate

  // The analog path is a plain wire to the pad, untouched by overrides.
  assign analog_pad_path = pad_in;
  assign pin_change_src = di;
  assign timer1_ext_clock_in = di[4];
  assign spi_master_in = di[3];
  assign serial_prog_data_out = pad_out[3];
  assign spi_slave_in = di[2];
  assign serial_prog_data_in = di[2];
  assign spi_sck_in = di[1];
  assign spi_ss_in = di[0];

  // Write strobes are decoded once and shared by all pins.
  assign do_write = aw_have_q & w_have_q & ~bvalid_q;
  assign port_data_write_strobe = do_write & wlane_q &
                                  hit(awaddr_q, `PPOM_OFF_DATA);
  assign pin_toggle_write_strobe = do_write & wlane_q &
                                   hit(awaddr_q, `PPOM_OFF_PIN);
  assign pin_read_strobe = s_axi_arvalid & ar_rdy_q &
                           hit(s_axi_araddr, `PPOM_OFF_PIN);

  // Edges are seen on the clamped input, so leaving deep sleep with a high
  // pin and the interrupt disabled raises the flag.
  assign events = (sample ^ sample_prev_q) & edgeen_q;

  always @* begin
    data_d = data_q;
    if (port_data_write_strobe) begin
      data_d = wdata_q;
    end
    if (pin_toggle_write_strobe) begin
      data_d = data_d ^ wdata_q;
    end
    data_d = data_d ^ toggle_override_en;
    status_d = status_q;
    if (do_write & wlane_q & hit(awaddr_q, `PPOM_OFF_STATUS)) begin
      status_d = status_d & ~wdata_q;
    end
    status_d = status_d | events;
  end

  always @* begin
    rd_ok = mapped(s_axi_araddr);
    rd_val = {WIDTH{1'b0}};
    if (hit(s_axi_araddr, `PPOM_OFF_DIR)) begin
      rd_val = dir_q;
    end else if (hit(s_axi_araddr, `PPOM_OFF_DATA)) begin
      rd_val = data_q;
    end else if (pin_read_strobe) begin
      rd_val = sample;
    end else if (hit(s_axi_araddr, `PPOM_OFF_CTRL)) begin
      rd_val = {{(WIDTH-`PPOM_CTRL_W){1'b0}}, ctrl_q};
    end else if (hit(s_axi_araddr, `PPOM_OFF_STATUS)) begin
      rd_val = status_q;
    end else if (hit(s_axi_araddr, `PPOM_OFF_MASK)) begin
      rd_val = mask_q;
    end else if (hit(s_axi_araddr, `PPOM_OFF_EXTEN)) begin
      rd_val = exten_q;
    end else if (hit(s_axi_araddr, `PPOM_OFF_EDGEEN)) begin
      rd_val = edgeen_q;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dir_q <= `PPOM_RST_DIR;
      data_q <= `PPOM_RST_DATA;
      ctrl_q <= `PPOM_RST_CTRL;
      status_q <= `PPOM_RST_STATUS;
      mask_q <= `PPOM_RST_MASK;
      exten_q <= `PPOM_RST_EXTEN;
      edgeen_q <= `PPOM_RST_EDGEEN;
      sample_prev_q <= {WIDTH{1'b0}};
      irq_q <= 1'b0;
    end else begin
      data_q <= data_d;
      status_q <= status_d;
      sample_prev_q <= sample;
      irq_q <= |(status_d & mask_q);
      if (do_write & wlane_q) begin
        if (hit(awaddr_q, `PPOM_OFF_DIR)) begin
          dir_q <= wdata_q;
        end
        if (hit(awaddr_q, `PPOM_OFF_CTRL)) begin
          ctrl_q <= wdata_q[`PPOM_CTRL_W-1:0];
        end
        if (hit(awaddr_q, `PPOM_OFF_MASK)) begin
          mask_q <= wdata_q;
        end
        if (hit(awaddr_q, `PPOM_OFF_EXTEN)) begin
          exten_q <= wdata_q;
        end
        if (hit(awaddr_q, `PPOM_OFF_EDGEEN)) begin
          edgeen_q <= wdata_q;
        end
      end
    end
  end

  // Address and data are taken in either order; the response waits for both.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_rdy_q <= 1'b1;
      w_rdy_q <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= {`PPOM_ADDR_W{1'b0}};
      wdata_q <= {WIDTH{1'b0}};
      wlane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `PPOM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & aw_rdy_q) begin
        aw_have_q <= 1'b1;
        aw_rdy_q <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & w_rdy_q) begin
        w_have_q <= 1'b1;
        w_rdy_q <= 1'b0;
        wdata_q <= s_axi_wdata[WIDTH-1:0];
        wlane_q <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= mapped(awaddr_q) ? `PPOM_RESP_OKAY : `PPOM_RESP_SLVERR;
      end
      if (bvalid_q & s_axi_bready) begin
        bvalid_q <= 1'b0;
        aw_rdy_q <= 1'b1;
        w_rdy_q <= 1'b1;
      end
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ar_rdy_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `PPOM_RESP_OKAY;
    end else begin
      if (s_axi_arvalid & ar_rdy_q) begin
        ar_rdy_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= {{(32-WIDTH){1'b0}}, rd_val};
        rresp_q <= rd_ok ? `PPOM_RESP_OKAY : `PPOM_RESP_SLVERR;
      end
      if (rvalid_q & s_axi_rready) begin
        rvalid_q <= 1'b0;
        ar_rdy_q <= 1'b1;
      end
    end
  end

  assign s_axi_awready = aw_rdy_q;
  assign s_axi_wready = w_rdy_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ar_rdy_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign irq = irq_q;
endmodule // ppom_port

// >>> hw/ppom_map.vh
// Register offsets, field positions, reset values and sleep codes of the
// port pin override block. Assumes a 32-bit AXI4-Lite slave, one word per
// register, and an 8-bit port.
`ifndef PPOM_MAP_VH
`define PPOM_MAP_VH

`define PPOM_ADDR_W 8
`define PPOM_OFF_DIR 8'h00
`define PPOM_OFF_DATA 8'h04
`define PPOM_OFF_PIN 8'h08
`define PPOM_OFF_CTRL 8'h0C
`define PPOM_OFF_STATUS 8'h10
`define PPOM_OFF_MASK 8'h14
`define PPOM_OFF_EXTEN 8'h18
`define PPOM_OFF_EDGEEN 8'h1C

`define PPOM_CTRL_PUD_BIT 0
`define PPOM_CTRL_PCIE_BIT 1
`define PPOM_CTRL_W 2

`define PPOM_RST_DIR 8'h00
`define PPOM_RST_DATA 8'h00
`define PPOM_RST_CTRL 2'h0
`define PPOM_RST_STATUS 8'h00
`define PPOM_RST_MASK 8'h00
`define PPOM_RST_EXTEN 8'h00
`define PPOM_RST_EDGEEN 8'h00

`define PPOM_SLP_W 3
`define PPOM_SLP_IDLE 3'h0
`define PPOM_SLP_PDOWN 3'h2
`define PPOM_SLP_PSAVE 3'h3
`define PPOM_SLP_STANDBY 3'h6

`define PPOM_RESP_OKAY 2'h0
`define PPOM_RESP_SLVERR 2'h2

`endif

// >>> hw/ppom_pin_cell.v
// One port pin: override selection, sleep clamp and input synchroniser.
// Assumes the stored direction and data bits live in the register bank.
`timescale 1ns/100ps
module ppom_pin_cell (
  input wire clock,
  input wire rst_n,
  input wire pad_in,
  input wire pin_direction_bit,
  input wire pin_output_data_bit,
  input wire global_pullup_disable,
  input wire sleep_clamp,
  input wire ext_int_en,
  input wire pullup_override_en,
  input wire pullup_override_val,
  input wire dir_override_en,
  input wire dir_override_val,
  input wire outval_override_en,
  input wire outval_override_val,
  input wire inen_override_en,
  input wire inen_override_val,
  output wire pad_out,
  output wire pad_oe,
  output wire pullup_en,
  output wire periph_digital_in,
  output wire pin_input_sample_bit
);
  wire drv_en;
  wire pu_sel;
  wire clamp;
  wire in_en;
  reg sync_lo_q;
  reg sync_q;

  // Selection is pure logic so an override reaches the pad with no latency.
  assign drv_en = dir_override_en ? dir_override_val
                                  : pin_direction_bit;
  assign pu_sel = pullup_override_en ? pullup_override_val
                : ({pin_direction_bit, pin_output_data_bit,
                    global_pullup_disable} == 3'b010);
  // Reset gates the pad directly so the pin floats even with no clock.
  assign pad_oe = drv_en & rst_n;
  assign pullup_en = pu_sel & rst_n;
  assign pad_out = outval_override_en ? outval_override_val
                                      : pin_output_data_bit;
  assign clamp = sleep_clamp & ~ext_int_en;
  assign in_en = inen_override_en ? inen_override_val : ~clamp;
  // Tapped ahead of the synchroniser; receivers resynchronise.
  assign periph_digital_in = pad_in & in_en;

  // A falling-edge stage stands for the latch that closes when the clock
  // goes low, giving half to one and a half periods of delay.
  always @(negedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_lo_q <= 1'b0;
    end else begin
      sync_lo_q <= periph_digital_in;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_q <= 1'b0;
    end else begin
      sync_q <= sync_lo_q;
    end
  end

  assign pin_input_sample_bit = sync_q;
endmodule // ppom_pin_cell

// >>> verification/ppom_port_properties.sv
// Checker for the port pin override block, watching its ports only.
// Assumes one clock domain; it is bound to ppom_port at the foot.
`timescale 1ns/100ps
module ppom_port_props #(
  parameter WIDTH = 8
) (
  input wire clock,
  input wire rst_n,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire sleep_active,
  input wire spi_enable,
  input wire spi_master,
  input wire timer0_compare_a_en,
  input wire timer0_compare_a_out,
  input wire timer1_compare_c_en,
  input wire timer1_compare_c_out,
  input wire [WIDTH-1:0] toggle_override_en,
  input wire [WIDTH-1:0] pin_change_src,
  input wire timer1_ext_clock_in,
  input wire spi_master_in,
  input wire spi_slave_in,
  input wire spi_sck_in,
  input wire spi_ss_in,
  input wire serial_prog_data_in,
  input wire serial_prog_data_out,
  input wire [WIDTH-1:0] pad_in,
  input wire [WIDTH-1:0] pad_out,
  input wire [WIDTH-1:0] pad_oe,
  input wire [WIDTH-1:0] analog_pad_path
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire spim = spi_enable && spi_master;
  sequence s_tog;
    toggle_override_en[0] && pad_oe[0];
  endsequence
  // A software write in the same cycle may mask the flip, so skip it.
  sequence s_quiet;
    pad_oe[0] && !$rose(s_axi_bvalid);
  endsequence
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_live;
    !sleep_active |-> pin_change_src == pad_in;
  endproperty
  a_live: assert property (p_live) else $error("input not live");
  property p_ana;
    analog_pad_path == pad_in;
  endproperty
  a_ana: assert property (p_ana) else $error("analog path");
  property p_ddo;
    spim |-> pad_oe[3:0] == 4'h0;
  endproperty
  a_ddo: assert property (p_ddo) else $error("spi driver on");
  property p_t0;
    timer0_compare_a_en && pad_oe[7] |-> pad_out[7] == timer0_compare_a_out;
  endproperty
  a_t0: assert property (p_t0) else $error("bit 7 compare a");
  property p_t1;
    timer1_compare_c_en && !timer0_compare_a_en && pad_oe[7]
      |-> pad_out[7] == timer1_compare_c_out;
  endproperty
  a_t1: assert property (p_t1) else $error("bit 7 compare c");
  property p_b4;
    timer1_ext_clock_in == pin_change_src[4];
  endproperty
  a_b4: assert property (p_b4) else $error("timer clock tap");
  property p_b30;
    {spi_master_in, spi_slave_in, spi_sck_in, spi_ss_in} == pin_change_src[3:0]
      && serial_prog_data_in == pin_change_src[2]
      && serial_prog_data_out == pad_out[3];
  endproperty
  a_b30: assert property (p_b30) else $error("spi taps");
  property p_tog;
    s_tog ##1 s_quiet |-> pad_out[0] != $past(pad_out[0]);
  endproperty
  a_tog: assert property (p_tog) else $error("toggle missed");
  property p_wr;
    s_wr |-> ##2 s_axi_bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("write answer late");
  property p_rd;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
endmodule // ppom_port_props
bind ppom_port ppom_port_props #(.WIDTH(WIDTH)) chk_u (.*);

// >>> verification/ppom_pad_model.sv
// Board model for the port pins: resolves drivers and pull-ups.
// Assumes the bench says per pin whether an outside driver is present.
`timescale 1ns/100ps
module ppom_pad_model (
  input wire clock,
  input wire [7:0] pad_out,
  input wire [7:0] pad_oe,
  input wire [7:0] pullup_en,
  input wire [7:0] ext_en,
  input wire [7:0] ext_val,
  output wire [7:0] pad_in
);
  reg [7:0] float_q = 8'h55;
  // A floating pin wanders so that no stale level reads as a match.
  always @(posedge clock) float_q <= ~float_q;
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) |
    (~pad_oe & ~ext_en & (pullup_en | float_q));
endmodule // ppom_pad_model

// >>> verification/ppom_port_tb_top.sv
// Testbench for the port pin override block: bus tasks and pin tests.
// Assumes the pad model stands for the board around the pins.
`timescale 1ns/100ps
`include "ppom_map.vh"
module ppom_port_tb_top;
  logic clock = 1'h0, rst_n = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, irq, timer1_ext_clock_in, spi_master_in;
  wire spi_slave_in, spi_sck_in, spi_ss_in;
  wire serial_prog_data_in, serial_prog_data_out;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] pin_change_src, pad_in, pad_out, pad_oe, pullup_en;
  wire [7:0] analog_pad_path;
  logic sleep_active = 1'h0, spi_enable = 1'h0, spi_master = 1'h0;
  logic [2:0] sleep_mode = 3'h0;
  logic [7:0] toggle_override_en = 8'h00, ext_en = 8'hFF, ext_val = 8'h00;
  logic spi_slave_out = 1'h0, spi_master_out = 1'h0, spi_sck_out = 1'h0;
  logic timer0_compare_a_en = 1'h0, timer0_compare_a_out = 1'h0;
  logic timer1_compare_c_en = 1'h0, timer1_compare_c_out = 1'h0;
  logic [2:0] modes [4] = '{3'h0, 3'h2, 3'h3, 3'h6};
  localparam logic [1:0] OK = `PPOM_RESP_OKAY;
  localparam logic [1:0] SE = `PPOM_RESP_SLVERR;
  int errors = 0, check_count = 0, cyc = 0, i;
  ppom_port dut_u (.*);
  ppom_pad_model pad_u (.clock, .pad_out, .pad_oe, .pullup_en, .ext_en,
    .ext_val, .pad_in);
  always #25 clock = ~clock;
  task give_verdict;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // The whole run needs a few hundred cycles; this ceiling cuts a hang.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      give_verdict;
    end
  end
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task settle;
    @(negedge clock);
  endtask
  task axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk("bresp", s_axi_bresp, er);
  endtask
  task axr(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk("rdata", s_axi_rdata, {24'h000000, e});
    chk("rresp", s_axi_rresp, er);
  endtask
  task slp(input logic [2:0] m, input logic e);
    @(posedge clock);
    sleep_active <= 1'h1;
    sleep_mode <= m;
    settle;
    chk("pin6_in", pin_change_src[6], e);
    @(posedge clock);
    sleep_active <= 1'h0;
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'h1;
    for (i = 0; i < 8; i++) axr(8'(i * 4), 8'h00, OK);
    axr(8'h20, 8'h00, SE);
    axw(8'h20, 8'hFF, SE);
    axw(`PPOM_OFF_DATA, 8'hFF, OK);
    axw(`PPOM_OFF_DIR, 8'h0F, OK);
    settle;
    chk("pullup", pullup_en, 8'hF0);
    chk("oe", pad_oe, 8'h0F);
    chk("out", pad_out[3:0], 4'hF);
    axw(`PPOM_OFF_CTRL, 8'h01, OK);
    settle;
    chk("pullup_pud", pullup_en, 8'h00);
    axw(`PPOM_OFF_CTRL, 8'h00, OK);
    axw(`PPOM_OFF_PIN, 8'h0F, OK);
    axr(`PPOM_OFF_DATA, 8'hF0, OK);
    @(posedge clock);
    toggle_override_en <= 8'h01;
    @(posedge clock);
    toggle_override_en <= 8'h00;
    axr(`PPOM_OFF_DATA, 8'hF1, OK);
    $display("test port bits done");
    @(posedge clock);
    spi_enable <= 1'h1;
    spi_master <= 1'h1;
    spi_slave_out <= 1'h1;
    spi_master_out <= 1'h1;
    spi_sck_out <= 1'h1;
    settle;
    chk("oe_spi", pad_oe[3:0], 4'h0);
    chk("prog_out", serial_prog_data_out, 1'h1);
    axw(`PPOM_OFF_CTRL, 8'h01, OK);
    settle;
    chk("pullup_spi", pullup_en, 8'h01);
    axw(`PPOM_OFF_CTRL, 8'h00, OK);
    spi_enable <= 1'h0;
    axw(`PPOM_OFF_DIR, 8'h8F, OK);
    timer0_compare_a_en <= 1'h1;
    timer1_compare_c_en <= 1'h1;
    timer1_compare_c_out <= 1'h1;
    settle;
    chk("bit7_a", pad_out[7], 1'h0);
    @(posedge clock);
    timer0_compare_a_en <= 1'h0;
    timer1_compare_c_out <= 1'h0;
    timer0_compare_a_out <= 1'h1;
    settle;
    chk("bit7_c", pad_out[7], 1'h0);
    @(posedge clock);
    timer1_compare_c_en <= 1'h0;
    timer0_compare_a_out <= 1'h0;
    settle;
    chk("bit7_data", pad_out[7], 1'h1);
    $display("test overrides done");
    axw(`PPOM_OFF_DIR, 8'h00, OK);
    axw(`PPOM_OFF_EDGEEN, 8'h20, OK);
    axw(`PPOM_OFF_MASK, 8'h20, OK);
    ext_val <= 8'h20;
    repeat (2) @(posedge clock);
    axr(`PPOM_OFF_PIN, 8'h20, OK);
    axr(`PPOM_OFF_STATUS, 8'h20, OK);
    chk("irq_on", irq, 1'h1);
    axw(`PPOM_OFF_MASK, 8'h00, OK);
    settle;
    chk("irq_masked", irq, 1'h0);
    axw(`PPOM_OFF_MASK, 8'h20, OK);
    axw(`PPOM_OFF_STATUS, 8'h20, OK);
    settle;
    chk("irq_clear", irq, 1'h0);
    axr(`PPOM_OFF_STATUS, 8'h00, OK);
    $display("test events done");
    ext_val <= 8'h40;
    axw(`PPOM_OFF_EDGEEN, 8'h40, OK);
    for (i = 0; i < 4; i++) slp(modes[i], modes[i] == 3'h0);
    axw(`PPOM_OFF_EXTEN, 8'h40, OK);
    slp(`PPOM_SLP_PDOWN, 1'h1);
    axw(`PPOM_OFF_EXTEN, 8'h00, OK);
    axw(`PPOM_OFF_CTRL, 8'h02, OK);
    slp(`PPOM_SLP_STANDBY, 1'h1);
    axw(`PPOM_OFF_CTRL, 8'h00, OK);
    sleep_mode <= `PPOM_SLP_PSAVE;
    sleep_active <= 1'h1;
    repeat (3) @(posedge clock);
    axw(`PPOM_OFF_STATUS, 8'hFF, OK);
    sleep_active <= 1'h0;
    repeat (4) @(posedge clock);
    axr(`PPOM_OFF_STATUS, 8'h40, OK);
    $display("test sleep done");
    axw(`PPOM_OFF_DIR, 8'h0F, OK);
    settle;
    chk("pullup_pre", pullup_en, 8'hF0);
    @(posedge clock);
    ext_en <= 8'h00;
    repeat (2) @(posedge clock);
    axr(`PPOM_OFF_PIN, 8'hF1, OK);
    @(posedge clock);
    rst_n <= 1'h0;
    #1;
    chk("oe_rst", pad_oe, 8'h00);
    chk("pullup_rst", pullup_en, 8'h00);
    repeat (5) @(posedge clock);
    rst_n <= 1'h1;
    axr(`PPOM_OFF_DATA, 8'h00, OK);
    $display("test reset done");
    give_verdict;
  end
endmodule // ppom_port_tb_top
